// ---- hw/ivp_pkg.sv ----
// Constants for the interrupt vector and priority map.
// Assumes a single 100 MHz core clock; no software-reachable registers.
`default_nettype none
package ivp_pkg;
   localparam int unsigned SLOT_FIRST = 23;
   localparam int unsigned SLOT_LAST  = 61;
   localparam int unsigned NUM_SLOTS  = 39;
   localparam int unsigned SLOT_W     = 6;
   localparam int unsigned LEVEL_W    = 3;
   localparam int unsigned CODE_W     = 16;
   localparam int unsigned ADDR_W     = 32;

   localparam logic [CODE_W-1:0] CODE_BASE = 16'h0080;
   localparam logic [CODE_W-1:0] CODE_STEP = 16'h0010;
   localparam logic [CODE_W-1:0] CODE_PIN_NMI = 16'h0010;
   localparam logic [CODE_W-1:0] CODE_WDT_NMI = 16'h0020;
   localparam logic [CODE_W-1:0] CODE_ILLEGAL = 16'h0060;
   localparam logic [CODE_W-1:0] CODE_TRAP0   = 16'h0040;
   localparam logic [CODE_W-1:0] CODE_TRAP1   = 16'h0050;
   localparam logic [ADDR_W-1:0] ADDR_TRAP0   = 32'h0000_0040;
   localparam logic [ADDR_W-1:0] ADDR_TRAP1   = 32'h0000_0050;
   localparam logic [ADDR_W-1:0] ILLEGAL_PC_BACK = 32'h0000_0004;

   localparam int unsigned SLOT_TIMER4_MATCH0 = 27;
   localparam int unsigned SLOT_SERIAL0_RX    = 33;
   localparam int unsigned SLOT_SERIAL0_TX    = 34;
   localparam int unsigned SLOT_UART0_RX      = 41;
   localparam int unsigned SLOT_UART1_TX      = 44;
   localparam int unsigned SLOT_UART2_TX      = 46;
   localparam int unsigned SLOT_UARTC_TX      = 61;
   localparam int unsigned SLOT_VARIANT_FIRST = 55;

   typedef enum logic [2:0] {
      IVP_KIND_NONE,
      IVP_KIND_PIN_NMI,
      IVP_KIND_WDT_NMI,
      IVP_KIND_MASKABLE,
      IVP_KIND_TRAP,
      IVP_KIND_ILLEGAL
   } ivp_kind_type;
endpackage
`default_nettype wire

// ---- hw/ivp_slot_code.sv ----
// Maps a default-priority slot to its exception code and handler address.
// Assumes the slot lies in the maskable range; code rises by 10H per slot.
`default_nettype none
module ivp_slot_code (
   // Slot in
   input  wire logic [ivp_pkg::SLOT_W-1:0] slot_i,
   // Code and address out
   output logic      [ivp_pkg::CODE_W-1:0] code_o,
   output logic      [ivp_pkg::ADDR_W-1:0] addr_o
);
   logic [ivp_pkg::CODE_W-1:0] slot_ext;
   always_comb begin
      slot_ext = {{(ivp_pkg::CODE_W-ivp_pkg::SLOT_W){1'b0}}, slot_i};
      code_o   = ivp_pkg::CODE_BASE + (slot_ext << 4);
      addr_o   = {{(ivp_pkg::ADDR_W-ivp_pkg::CODE_W){1'b0}}, code_o};
   end
endmodule
`default_nettype wire

// ---- hw/ivp_resolve.sv ----
// Picks the pending maskable slot with best level, then smallest number.
// Assumes requests are already masked by their owners.
`default_nettype none
module ivp_resolve (
   // Requests and levels, index 0 is slot 23
   input  wire logic [ivp_pkg::NUM_SLOTS-1:0]                      req_i,
   input  wire logic [ivp_pkg::NUM_SLOTS-1:0][ivp_pkg::LEVEL_W-1:0] level_i,
   // Winner
   output logic                                                    any_o,
   output logic      [ivp_pkg::SLOT_W-1:0]                         slot_o,
   output logic      [ivp_pkg::LEVEL_W-1:0]                        level_o
);
   always_comb begin
      any_o   = 1'b0;
      slot_o  = '0;
      level_o = '1;
      // Scan downward so a smaller slot wins a tie
      for (int i = ivp_pkg::NUM_SLOTS-1; i >= 0; i--) begin
         if (req_i[i] && (!any_o || level_i[i] <= level_o)) begin
            any_o   = 1'b1;
            slot_o  = ivp_pkg::SLOT_W'(i + ivp_pkg::SLOT_FIRST);
            level_o = level_i[i];
         end
      end
   end
endmodule
`default_nettype wire

// ---- hw/ivp_top.sv ----
// Vector and priority map for maskable slots 23..61 and the two NMIs.
// Assumes synchronous request levels; the core pulses accept_i when it takes the offered event.
`default_nettype none
module ivp_top #(
   parameter bit VARIANT_PRESENT = 1'b1
) (
   // Clock and reset
   input  wire logic                                              core_clk_i,
   input  wire logic                                              reset_n_i,
   // Dedicated request lines, one per slot, index 0 is slot 23
   input  wire logic [ivp_pkg::NUM_SLOTS-1:0]                     slot_req_i,
   input  wire logic [ivp_pkg::NUM_SLOTS-1:0][ivp_pkg::LEVEL_W-1:0] slot_level_i,
   // Alternate members of shared slots
   input  wire logic                                              twowire1_done_request_i,
   input  wire logic                                              serial4_receive_request_i,
   input  wire logic                                              alt23_request_i,
   input  wire logic                                              alt25_request_i,
   input  wire logic                                              alt42_request_i,
   input  wire logic                                              alt43_request_i,
   input  wire logic                                              alt45_request_i,
   input  wire logic                                              alt53_request_i,
   input  wire logic                                              alt54_request_i,
   // Non-maskable and core-side events
   input  wire logic                                              pin_nmi_request_i,
   input  wire logic                                              watchdog_nonmask_request_i,
   input  wire logic                                              trap_i,
   input  wire logic [4:0]                                        trap_vector_i,
   input  wire logic                                              illegal_opcode_trap_i,
   input  wire logic [ivp_pkg::ADDR_W-1:0]                        fault_pc_i,
   input  wire logic                                              maskable_enable_i,
   input  wire logic                                              accept_i,
   // Offer to the core
   output logic                                                   offer_valid_o,
   output ivp_pkg::ivp_kind_type                                  offer_kind_o,
   output logic      [ivp_pkg::CODE_W-1:0]                        offer_code_o,
   output logic      [ivp_pkg::ADDR_W-1:0]                        offer_addr_o,
   output logic      [ivp_pkg::LEVEL_W-1:0]                       offer_level_o,
   // Taken state
   output logic      [ivp_pkg::CODE_W-1:0]                        maskable_cause_field_o,
   output logic      [ivp_pkg::CODE_W-1:0]                        nonmask_cause_field_o,
   output logic      [ivp_pkg::ADDR_W-1:0]                        saved_pc_o,
   output logic                                                   taken_o
);
   typedef struct packed {
      logic [ivp_pkg::CODE_W-1:0] maskable_cause_field;
      logic [ivp_pkg::CODE_W-1:0] nonmask_cause_field;
      logic [ivp_pkg::ADDR_W-1:0] saved_pc;
      logic                       taken;
      ivp_pkg::ivp_kind_type      kind;
      logic [ivp_pkg::CODE_W-1:0] code;
      logic [ivp_pkg::ADDR_W-1:0] addr;
      logic [ivp_pkg::LEVEL_W-1:0] level;
   } ivp_state_type;

   ivp_state_type state;
   ivp_state_type next_state;

   logic [ivp_pkg::NUM_SLOTS-1:0] merged_req;
   logic [ivp_pkg::NUM_SLOTS-1:0] alt_req;
   logic                          win_any;
   logic [ivp_pkg::SLOT_W-1:0]    win_slot;
   logic [ivp_pkg::LEVEL_W-1:0]   win_level;
   logic [ivp_pkg::CODE_W-1:0]    win_code;
   logic [ivp_pkg::ADDR_W-1:0]    win_addr;

   // Alternate members folded onto their shared slots
   always_comb begin
      alt_req = '0;
      alt_req[ivp_pkg::SLOT_SERIAL0_RX-ivp_pkg::SLOT_FIRST] = twowire1_done_request_i;
      alt_req[ivp_pkg::SLOT_UART0_RX-ivp_pkg::SLOT_FIRST]   = serial4_receive_request_i;
      alt_req[42-ivp_pkg::SLOT_FIRST] = alt42_request_i;
      alt_req[43-ivp_pkg::SLOT_FIRST] = alt43_request_i;
      alt_req[45-ivp_pkg::SLOT_FIRST] = alt45_request_i;
      alt_req[23-ivp_pkg::SLOT_FIRST] = alt23_request_i && VARIANT_PRESENT;
      alt_req[25-ivp_pkg::SLOT_FIRST] = alt25_request_i && VARIANT_PRESENT;
      alt_req[53-ivp_pkg::SLOT_FIRST] = alt53_request_i && VARIANT_PRESENT;
      alt_req[54-ivp_pkg::SLOT_FIRST] = alt54_request_i && VARIANT_PRESENT;
   end

   // Slot requests: dedicated line OR shared member, variant slots gated
   genvar g;
   generate
      for (g = 0; g < ivp_pkg::NUM_SLOTS; g++) begin : gen_slot
         if (g + ivp_pkg::SLOT_FIRST >= ivp_pkg::SLOT_VARIANT_FIRST) begin : gen_var
            assign merged_req[g] = slot_req_i[g] && VARIANT_PRESENT;
         end else begin : gen_fix
            assign merged_req[g] = slot_req_i[g] || alt_req[g];
         end
      end
   endgenerate

   ivp_resolve u_resolve (
      .req_i   (merged_req),
      .level_i (slot_level_i),
      .any_o   (win_any),
      .slot_o  (win_slot),
      .level_o (win_level)
   );

   // Slots 27, 33, 34, 41, 44, 46 and 61 follow the uniform code ladder
   ivp_slot_code u_code (
      .slot_i (win_slot),
      .code_o (win_code),
      .addr_o (win_addr)
   );

   always_comb begin
      next_state       = state;
      next_state.taken = 1'b0;
      // Fixed order: watchdog NMI, pin NMI, illegal, trap, maskable
      if (watchdog_nonmask_request_i) begin
         next_state.kind = ivp_pkg::IVP_KIND_WDT_NMI;
         next_state.code = ivp_pkg::CODE_WDT_NMI;
         next_state.addr = {16'h0000, ivp_pkg::CODE_WDT_NMI};
      end else if (pin_nmi_request_i) begin
         next_state.kind = ivp_pkg::IVP_KIND_PIN_NMI;
         next_state.code = ivp_pkg::CODE_PIN_NMI;
         next_state.addr = {16'h0000, ivp_pkg::CODE_PIN_NMI};
      end else if (illegal_opcode_trap_i) begin
         next_state.kind = ivp_pkg::IVP_KIND_ILLEGAL;
         next_state.code = ivp_pkg::CODE_ILLEGAL;
         next_state.addr = {16'h0000, ivp_pkg::CODE_ILLEGAL};
      end else if (trap_i) begin
         next_state.kind = ivp_pkg::IVP_KIND_TRAP;
         next_state.code = (trap_vector_i[4] ? ivp_pkg::CODE_TRAP1 : ivp_pkg::CODE_TRAP0)
                           | {12'h000, trap_vector_i[3:0]};
         next_state.addr = trap_vector_i[4] ? ivp_pkg::ADDR_TRAP1 : ivp_pkg::ADDR_TRAP0;
      end else if (win_any && maskable_enable_i) begin
         next_state.kind = ivp_pkg::IVP_KIND_MASKABLE;
         next_state.code = win_code;
         next_state.addr = win_addr;
      end else begin
         next_state.kind = ivp_pkg::IVP_KIND_NONE;
         next_state.code = '0;
         next_state.addr = '0;
      end
      next_state.level = win_level;
      // Acceptance applies to what was offered last cycle
      if (accept_i && state.kind != ivp_pkg::IVP_KIND_NONE) begin
         next_state.taken = 1'b1;
         case (state.kind)
            ivp_pkg::IVP_KIND_WDT_NMI,
            ivp_pkg::IVP_KIND_PIN_NMI: begin
               next_state.nonmask_cause_field = state.code;
               next_state.saved_pc            = fault_pc_i;
            end
            ivp_pkg::IVP_KIND_ILLEGAL: begin
               next_state.maskable_cause_field = state.code;
               next_state.saved_pc = fault_pc_i + ivp_pkg::ILLEGAL_PC_BACK;
            end
            ivp_pkg::IVP_KIND_TRAP,
            ivp_pkg::IVP_KIND_MASKABLE: begin
               next_state.maskable_cause_field = state.code;
               next_state.saved_pc             = fault_pc_i;
            end
            default: begin
               next_state.taken = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign offer_valid_o          = state.kind != ivp_pkg::IVP_KIND_NONE;
   assign offer_kind_o           = state.kind;
   assign offer_code_o           = state.code;
   assign offer_addr_o           = state.addr;
   assign offer_level_o          = state.level;
   assign maskable_cause_field_o = state.maskable_cause_field;
   assign nonmask_cause_field_o  = state.nonmask_cause_field;
   assign saved_pc_o             = state.saved_pc;
   assign taken_o                = state.taken;
endmodule
`default_nettype wire

// ---- dv/ivp_chk.sv ----
// Port assertions for ivp_top.
// Assumes one clock domain; bound from the bench top file.
`default_nettype none
module ivp_chk (
   // Clock, reset and inputs
   input wire logic                 core_clk_i,
   input wire logic                 reset_n_i,
   input wire logic                 pin_nmi_request_i,
   input wire logic                 watchdog_nonmask_request_i,
   input wire logic [31:0]          fault_pc_i,
   input wire logic                 accept_i,
   // Outputs
   input wire logic                 offer_valid_o,
   input var ivp_pkg::ivp_kind_type offer_kind_o,
   input wire logic [15:0]          offer_code_o,
   input wire logic [31:0]          offer_addr_o,
   input wire logic [15:0]          maskable_cause_field_o,
   input wire logic [15:0]          nonmask_cause_field_o,
   input wire logic [31:0]          saved_pc_o,
   input wire logic                 taken_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic took;
   assign took = accept_i && offer_valid_o;
   AST_WDT_FIRST: assert property (watchdog_nonmask_request_i |=> offer_code_o == 16'h0020)
      else $error("watchdog not first");
   AST_PIN_CODE: assert property (pin_nmi_request_i && !watchdog_nonmask_request_i |=> offer_code_o == 16'h0010)
      else $error("pin code wrong");
   AST_ILL_PC: assert property (took && offer_kind_o == ivp_pkg::IVP_KIND_ILLEGAL |=> saved_pc_o == $past(fault_pc_i) + 32'h0000_0004)
      else $error("saved pc wrong");
   AST_CAUSE_LOW: assert property (took && offer_code_o > 16'h0030 |=> maskable_cause_field_o == $past(offer_code_o))
      else $error("low cause wrong");
   AST_CAUSE_NMI: assert property (took && offer_code_o < 16'h0030 |=> nonmask_cause_field_o == $past(offer_code_o))
      else $error("nmi cause wrong");
   AST_TAKEN: assert property (took |=> taken_o ##1 (taken_o == $past(took)))
      else $error("taken pulse wrong");
   AST_NO_TAKE: assert property (!took |=> !taken_o)
      else $error("taken without accept");
   AST_ADDR: assert property (offer_valid_o && offer_code_o > 16'h0070 |-> offer_addr_o == {16'h0000, offer_code_o})
      else $error("handler address wrong");
   cover property (took && offer_kind_o == ivp_pkg::IVP_KIND_WDT_NMI);
   cover property (took && offer_kind_o == ivp_pkg::IVP_KIND_ILLEGAL);
   cover property (taken_o && maskable_cause_field_o == 16'h0290);
endmodule
`default_nettype wire

// ---- dv/ivp_core_model.sv ----
// Core-side acceptor: takes each standing offer once after a set wait.
// Assumes offers stand until their source drops the request.
`default_nettype none
module ivp_core_model (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   // Offer, wait and accept
   input  wire logic       offer_valid_i,
   input  wire logic [3:0] wait_i,
   output logic            accept_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt      <= 5'h00;
         accept_o <= 1'b0;
      end else begin
         // Single pulse; counter parks past the wait until the offer drops
         accept_o <= offer_valid_i && cnt == {1'b0, wait_i};
         if (!offer_valid_i)
            cnt <= 5'h00;
         else if (cnt <= {1'b0, wait_i})
            cnt <= cnt + 5'h01;
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_ivp_top.sv ----
// Self-checking bench for ivp_top against a core acceptor model.
// Assumes ivp_pkg, the checker and the acceptor model compile first.
`default_nettype none
module tb_ivp_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  core_clk_i = 1'b0;
   logic                  reset_n_i = 1'b0;
   logic                  maskable_enable_i = 1'b1;
   logic [38:0]           slot_req_i = '0;
   logic [38:0][2:0]      slot_level_i = '0;
   logic [8:0]            alt = '0;
   logic [3:0]            ev = '0;
   logic [4:0]            trap_vector_i = '0;
   logic [31:0]           fault_pc_i = '0;
   logic [3:0]            wait_c = '0;
   logic                  accept_i, offer_valid_o, taken_o;
   logic [2:0]            offer_level_o;
   logic [15:0]           offer_code_o, maskable_cause_field_o, nonmask_cause_field_o;
   logic [31:0]           offer_addr_o, saved_pc_o;
   ivp_pkg::ivp_kind_type offer_kind_o;
   logic                  lite_valid;
   int                    errors = 0, tests_run = 0, cycles = 0;
   always #5 core_clk_i = ~core_clk_i;
   ivp_top #(.VARIANT_PRESENT(1'b1)) u_dut (.core_clk_i, .reset_n_i, .slot_req_i, .slot_level_i,
      .twowire1_done_request_i(alt[0]), .serial4_receive_request_i(alt[1]), .alt23_request_i(alt[2]),
      .alt25_request_i(alt[3]), .alt42_request_i(alt[4]), .alt43_request_i(alt[5]),
      .alt45_request_i(alt[6]), .alt53_request_i(alt[7]), .alt54_request_i(alt[8]),
      .pin_nmi_request_i(ev[0]), .watchdog_nonmask_request_i(ev[1]), .trap_i(ev[2]), .trap_vector_i,
      .illegal_opcode_trap_i(ev[3]), .fault_pc_i, .maskable_enable_i, .accept_i, .offer_valid_o,
      .offer_kind_o, .offer_code_o, .offer_addr_o, .offer_level_o, .maskable_cause_field_o,
      .nonmask_cause_field_o, .saved_pc_o, .taken_o);
   ivp_core_model u_core (.core_clk_i, .reset_n_i, .offer_valid_i(offer_valid_o), .wait_i(wait_c),
      .accept_o(accept_i));
   // Variant-absent build on the same stimulus; its variant sources must never raise an offer
   ivp_top #(.VARIANT_PRESENT(1'b0)) u_dut_lite (.core_clk_i, .reset_n_i, .slot_req_i, .slot_level_i,
      .twowire1_done_request_i(alt[0]), .serial4_receive_request_i(alt[1]), .alt23_request_i(alt[2]),
      .alt25_request_i(alt[3]), .alt42_request_i(alt[4]), .alt43_request_i(alt[5]),
      .alt45_request_i(alt[6]), .alt53_request_i(alt[7]), .alt54_request_i(alt[8]),
      .pin_nmi_request_i(ev[0]), .watchdog_nonmask_request_i(ev[1]), .trap_i(ev[2]), .trap_vector_i,
      .illegal_opcode_trap_i(ev[3]), .fault_pc_i, .maskable_enable_i, .accept_i,
      .offer_valid_o(lite_valid), .offer_kind_o(), .offer_code_o(), .offer_addr_o(), .offer_level_o(),
      .maskable_cause_field_o(), .nonmask_cause_field_o(), .saved_pc_o(), .taken_o());
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Sources hold their request until the core has taken it
   task automatic take(input logic nm, input logic [15:0] code);
      for (int n = 0; n < 40 && taken_o !== 1'b1; n++) @(negedge core_clk_i);
      check(taken_o, 1'b1);
      check(nm ? nonmask_cause_field_o : maskable_cause_field_o, code);
      if (code > 16'h0070)
         check(offer_addr_o, {16'h0000, code});
      @(posedge core_clk_i);
      slot_req_i <= '0;
      alt <= '0;
      ev <= '0;
      repeat (3) @(posedge core_clk_i);
   endtask
   task automatic t_slots();
      int          bits[5] = '{4, 11, 21, 23, 38};
      logic [15:0] codes[5] = '{16'h0230, 16'h02A0, 16'h0340, 16'h0360, 16'h0450};
      foreach (bits[i]) begin
         @(posedge core_clk_i);
         wait_c <= 4'(i);
         slot_req_i[bits[i]] <= 1'b1;
         take(1'b0, codes[i]);
      end
   endtask
   task automatic t_alts();
      logic [15:0] codes[9] = '{16'h0290, 16'h0310, 16'h01F0, 16'h0210, 16'h0320, 16'h0330, 16'h0350,
                               16'h03D0, 16'h03E0};
      foreach (codes[i]) begin
         @(posedge core_clk_i);
         alt[i] <= 1'b1;
         repeat (2) @(negedge core_clk_i);
         check(lite_valid, !(i inside {2, 3, 7, 8}));
         take(1'b0, codes[i]);
      end
   endtask
   task automatic t_tie();
      @(posedge core_clk_i);
      slot_level_i <= {39{3'h5}};
      slot_req_i <= 39'h40_0020_0800;
      take(1'b0, 16'h02A0);
      @(posedge core_clk_i);
      slot_req_i <= 39'h00_00A0_0000;
      take(1'b0, 16'h0340);
      @(posedge core_clk_i);
      slot_req_i <= 39'h00_0000_0400;
      alt <= 9'h003;
      take(1'b0, 16'h0290);
      // A better level beats a smaller slot number
      @(posedge core_clk_i);
      slot_level_i[38] <= 3'h2;
      slot_req_i <= 39'h40_0000_0800;
      repeat (2) @(negedge core_clk_i);
      check(offer_level_o, 32'h0000_0002);
      take(1'b0, 16'h0450);
   endtask
   task automatic t_nmi();
      @(posedge core_clk_i);
      ev <= 4'h3;
      slot_req_i[4] <= 1'b1;
      take(1'b1, 16'h0020);
      @(posedge core_clk_i);
      ev <= 4'h1;
      take(1'b1, 16'h0010);
      @(posedge core_clk_i);
      ev <= 4'hC;
      trap_vector_i <= 5'h13;
      fault_pc_i <= 32'h0000_1F3C;
      repeat (2) @(negedge core_clk_i);
      check(offer_kind_o, ivp_pkg::IVP_KIND_ILLEGAL);
      take(1'b0, 16'h0060);
      check(saved_pc_o, 32'h0000_1F40);
      @(posedge core_clk_i);
      ev <= 4'h4;
      take(1'b0, 16'h0053);
   endtask
   task automatic t_off();
      @(posedge core_clk_i);
      maskable_enable_i <= 1'b0;
      slot_req_i[38] <= 1'b1;
      repeat (4) @(negedge core_clk_i);
      check(offer_valid_o, 1'b0);
      @(posedge core_clk_i);
      maskable_enable_i <= 1'b1;
      repeat (2) @(negedge core_clk_i);
      check(lite_valid, 1'b0);
      take(1'b0, 16'h0450);
   endtask
   initial begin
      repeat (10) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      t_slots();
      t_alts();
      t_tie();
      t_nmi();
      t_off();
      end_sim();
   end
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_sim();
      end
   end
endmodule
bind ivp_top ivp_chk u_chk (.core_clk_i, .reset_n_i, .pin_nmi_request_i, .watchdog_nonmask_request_i,
   .fault_pc_i, .accept_i, .offer_valid_o, .offer_kind_o, .offer_code_o, .offer_addr_o,
   .maskable_cause_field_o, .nonmask_cause_field_o, .saved_pc_o, .taken_o);
`default_nettype wire
